// ### inc/gcfg_consts.svh
// Constants of the general configuration register group: indices, masks, fields.
// Assumes the bus presents byte addresses whose word index is four times smaller.
`ifndef GCFG_CONSTS_SVH
`define GCFG_CONSTS_SVH

// Register indices; the byte address is four times the index.
`define IDX_GENERAL_CONFIG 8'hA9
`define IDX_XTALK_SLEEP    8'hAC
`define IDX_CALIB_TARGET   8'hED
`define IDX_STATUS         8'hF0
`define IDX_AUX_CONTROL    8'hF1
`define IDX_LOW_LAST       8'h7F
`define IDX_TABLE_FIRST    8'hB0
`define IDX_TABLE_LAST     8'hBF

// Address bits that carry the word index.
`define ADDR_IDX_LSB 2
`define ADDR_IDX_MSB 9

// Reset values and writable masks; bits outside a mask keep their reset value.
`define GEN_CFG_RESET 8'h00
`define GEN_CFG_MASK  8'h2F
`define XTALK_RESET   8'h0C
`define XTALK_MASK    8'h30
`define CALIB_RESET   8'h00
`define CALIB_MASK    8'hE0
`define AUX_RESET     8'h00
`define AUX_MASK      8'h01

// Field positions.
`define GEN_IDLE_BIT      5
`define GEN_PROX_LONG_BIT 3
`define GEN_WAIT_LONG_BIT 2
`define GEN_BANK_MSB      1
`define GEN_BANK_LSB      0
`define XTALK_SEL_A_BIT   5
`define XTALK_SLEEP_BIT   4
`define CALIB_FIELD_MSB   7
`define CALIB_FIELD_LSB   5
`define AUX_SEL_B_BIT     0
`define STAT_HALTED_BIT   0

// Calibration target exponent offset, end figures, and period stretch shift.
`define CALIB_EXP_OFFSET 4'h2
`define CALIB_MIN_COUNTS 9'h003
`define CALIB_MAX_COUNTS 9'h1FF
`define STRETCH_SHIFT    4

// Word memory layout: two banks of 128 words, then the 16-word time table.
`define LOW_IDX_MSB     6
`define TABLE_IDX_MSB   3
`define TABLE_BASE_ADDR 9'h100

// AXI response codes.
`define RESP_OKAY   2'b00
`define RESP_SLVERR 2'b10

`endif

// ### inc/gcfg_mem_if.sv
// Port between the register group and its word memory.
// Assumes one access per cycle with a registered read of one cycle.
`timescale 1ns/100ps
interface gcfg_mem_if #(
    parameter int AW = 9
);
    logic                  we;
    logic [AW-1:0]         addr;
    gcfg_pkg::byte_t       wdata;
    gcfg_pkg::byte_t       rdata;

    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem  (input we, input addr, input wdata, output rdata);
endinterface : gcfg_mem_if

// ### inc/gcfg_pkg.sv
// Types shared by the general configuration register group.
// Assumes the constants header supplies all offsets and field positions.
package gcfg_pkg;
    typedef logic [7:0] byte_t;
    typedef enum {ST_IDLE, ST_ACCESS, ST_FETCH, ST_BRESP, ST_RRESP} axil_state_e;
endpackage : gcfg_pkg

// ### verif/sensor_general_config_regs_bench.sv
// Self-checking bench for the general configuration register group over AXI4-Lite.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/100ps
`include "gcfg_consts.svh"
module sensor_general_config_regs_bench;
    import gcfg_pkg::*;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        all_funcs_idle = 0, int_n = 1, awready, wready, bvalid, arready, rvalid;
    logic        low_power_mode, high_xtalk_mode, osc_stop;
    logic [9:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [3:0]  wstrb = 0;
    logic [1:0]  bresp, rresp, r;
    byte_t       prox_sample_period = 0, wait_period = 0;
    logic [8:0]  calib_target;
    logic [11:0] prox_period_eff, wait_period_eff;
    int          mismatches = 0, n_compared = 0, cyc = 0, v, k, e[3];
    int          ri[3] = '{'hA9, 'hAC, 'hED}, rr[3] = '{0, 'h0C, 0};

    sensor_general_config_regs sensor_general_config_regs_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .prox_sample_period, .wait_period, .all_funcs_idle, .int_n, .calib_target,
        .low_power_mode, .prox_period_eff, .wait_period_eff, .high_xtalk_mode, .osc_stop);

    // Free-running clock; the cycle count cuts a hung handshake short.
    initial forever #4 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic give_verdict;
        if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Address and data are offered together and each is released when taken.
    task automatic wr(input int idx, input int dat);
        @(posedge aclk);
        awaddr <= 10'(idx << 2);
        wdata <= dat;
        wstrb <= 4'hF;
        awvalid <= 1;
        wvalid <= 1;
        fork
            begin do @(posedge aclk); while (awready !== 1); awvalid <= 0; end
            begin do @(posedge aclk); while (wready !== 1); wvalid <= 0; end
        join
        bready <= 1;
        do @(posedge aclk); while (bvalid !== 1);
        r = bresp;
        bready <= 0;
    endtask : wr

    task automatic rd(input int idx);
        @(posedge aclk);
        araddr <= 10'(idx << 2);
        arvalid <= 1;
        do @(posedge aclk); while (arready !== 1);
        arvalid <= 0;
        rready <= 1;
        do @(posedge aclk); while (rvalid !== 1);
        d = rdata;
        r = rresp;
        rready <= 0;
    endtask : rd

    initial begin
        void'($urandom(32'h4CA4E193));
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        foreach (ri[i]) begin
            rd(ri[i]);
            chk(d, rr[i]);
        end
        // every target code; reserved bits are written with their reset value.
        for (v = 0; v < 8; v++) begin
            wr(`IDX_CALIB_TARGET, v << 5);
            rd(`IDX_CALIB_TARGET);
            chk(d, v << 5);
            chk(calib_target, (1 << (v + 2)) - 1);
        end
        // random configuration against the period inputs.
        repeat (6) begin
            v = $urandom & 'h2F;
            wr(`IDX_GENERAL_CONFIG, v);
            prox_sample_period <= $urandom;
            wait_period <= $urandom;
            all_funcs_idle <= $urandom;
            rd(`IDX_GENERAL_CONFIG);
            chk(d, v & 'h2F);
            chk(prox_period_eff, 32'(prox_sample_period) << ((v >> 3 & 1) * 4));
            chk(wait_period_eff, 32'(wait_period) << ((v >> 2 & 1) * 4));
            chk(low_power_mode, (v >> 5 & 1) & all_funcs_idle);
        end
        // bank words and the mirrored time table.
        k = $urandom & 'h7F;
        foreach (e[i]) e[i] = $urandom & 'hFF;
        for (v = 0; v < 3; v++) begin
            wr(`IDX_GENERAL_CONFIG, v);
            wr(v == 2 ? 'hB0 + k % 16 : k, e[v]);
        end
        rd(k);
        chk(d, e[2]);
        wr(`IDX_GENERAL_CONFIG, 3);
        rd(k ^ 'h70);
        chk(d, e[2]);
        for (v = 0; v < 2; v++) begin
            wr(`IDX_GENERAL_CONFIG, v);
            rd(k);
            chk(d, e[v]);
        end
        // all four select combinations; the mode flag lags its registers by one edge.
        for (v = 0; v < 4; v++) begin
            wr(`IDX_XTALK_SLEEP, (v & 1) << 5 | 'h0C);
            wr(`IDX_AUX_CONTROL, v >> 1);
            @(posedge aclk);
            chk(high_xtalk_mode, v == 3);
        end
        // stop on interrupt, restart only after the flag is cleared.
        wr(`IDX_XTALK_SLEEP, 'h1C);
        int_n <= 0;
        repeat (8) @(posedge aclk);
        chk(osc_stop, 1);
        int_n <= 1;
        repeat (8) @(posedge aclk);
        rd(`IDX_STATUS);
        chk(d & 1, 1);
        chk(osc_stop, 1);
        wr(`IDX_STATUS, 1);
        chk(r, `RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk(osc_stop, 0);
        rd('hA0);
        chk(r, `RESP_SLVERR);
        wr('hA0, 'h55);
        chk(r, `RESP_SLVERR);
        give_verdict();
    end
endmodule : sensor_general_config_regs_bench

// ### verilog/gcfg_ram.sv
// Word memory holding both low-window banks and the time table.
// Assumes the controller never presents an address at or above DEPTH.
`timescale 1ns/100ps
module gcfg_ram #(
    parameter int DEPTH = 272
) (
    input wire logic  aclk,
    gcfg_mem_if.mem   port
);
    import gcfg_pkg::*;

    byte_t words [DEPTH];
    byte_t rdata_q;

    // Read first, read registered: a same-cycle write returns the old word; contents are not reset, as in a real macro.
    always_ff @(posedge aclk) begin
        if (port.we) begin
            words[port.addr] <= port.wdata;
        end
        rdata_q <= words[port.addr];
    end

    assign port.rdata = rdata_q;
endmodule : gcfg_ram

// ### verilog/gcfg_sync3.sv
// Three-stage synchroniser for a level arriving from a pin.
// Assumes the pin may change at any time relative to aclk.
`timescale 1ns/100ps
module gcfg_sync3 #(
    parameter logic IDLE_LEVEL = 1'b1
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic pin,
    output logic      level
);
    logic s1_q, s2_q, s3_q, level_q;

    // A change counts only once the second and third stages agree, which filters a late settle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q    <= IDLE_LEVEL;
            s2_q    <= IDLE_LEVEL;
            s3_q    <= IDLE_LEVEL;
            level_q <= IDLE_LEVEL;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end

    assign level = level_q;
endmodule : gcfg_sync3

// ### verilog/sensor_general_config_regs.sv
// General configuration register group of a light and proximity sensor, as an AXI4-Lite slave.
// Assumes a single aclk domain; the interrupt line arrives from a pin and is synchronised here.
//
// Notes on behaviour
// - The 3-bit calibration field sets a target of two to the power (field plus 2) minus one counts.
// - With idle power saving set, low-power mode follows whenever every function is idle or waiting.
// - With the proximity stretch bit set, the effective proximity sample period is sixteen times the setting.
// - With the light wait stretch bit set, the effective wait period is sixteen times the setting.
// - Bank select values 0 and 1 place RAM bank 0 or bank 1 in the low window 0x00 to 0x7F.
// - Bank select values 2 and 3 reach the sixteen-word time table held at 0xB0 to 0xBF.
// - While the table is selected, its sixteen words repeat over the whole low window.
// - In high-crosstalk mode the proximity engine uses its 10-bit output format.
// - High-crosstalk mode is on only while both select bits are set; one alone leaves normal output.
// - With sleep on interrupt set, the oscillator stops while the interrupt line is active low and stays stopped until the halted flag is cleared.
// - Each such stop sets the oscillator halted flag.
`timescale 1ns/100ps
`include "gcfg_consts.svh"
module sensor_general_config_regs #(
    parameter int ADDR_W    = 10,
    parameter int MEM_DEPTH = 272
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic             awvalid,
    output logic                  awready,
    input  wire logic [31:0]      wdata,
    input  wire logic [3:0]       wstrb,
    input  wire logic             wvalid,
    output logic                  wready,
    output logic [1:0]            bresp,
    output logic                  bvalid,
    input  wire logic             bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic             arvalid,
    output logic                  arready,
    output logic [31:0]           rdata,
    output logic [1:0]            rresp,
    output logic                  rvalid,
    input  wire logic             rready,
    input  wire gcfg_pkg::byte_t  prox_sample_period,
    input  wire gcfg_pkg::byte_t  wait_period,
    input  wire logic             all_funcs_idle,
    input  wire logic             int_n,
    output logic [8:0]            calib_target,
    output logic                  low_power_mode,
    output logic [11:0]           prox_period_eff,
    output logic [11:0]           wait_period_eff,
    output logic                  high_xtalk_mode,
    output logic                  osc_stop
);
    import gcfg_pkg::*;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Bus side state.
    axil_state_e         state_q, state_d;
    logic                aw_have_q, w_have_q, ar_have_q;
    logic                aw_have_d, w_have_d, ar_have_d;
    logic [ADDR_W-1:0]   aw_addr_q, ar_addr_q, req_addr_q;
    byte_t               w_data_q, req_data_q, rdata_q;
    logic                w_be_q, req_we_q, req_be_q;
    logic                awready_q, wready_q, arready_q, bvalid_q, rvalid_q;
    logic [1:0]          resp_q;
    logic                aw_take, w_take, ar_take, start_wr, start_rd;

    // Register file and derived outputs.
    byte_t               gen_cfg_q, xtalk_q, calib_q, aux_q;
    logic                osc_halted_q, osc_stop_q, low_power_q, high_xtalk_q;
    logic [8:0]          calib_target_q;
    logic [11:0]         prox_eff_q, wait_eff_q;
    logic                int_active, int_level;

    // Decode of the request in progress.
    byte_t               req_idx, reg_rd, stat_val;
    logic                upper_zero, hit_mem, hit_gen, hit_xtalk, hit_calib, hit_stat, hit_aux, hit_any;
    logic                wr_fire, sleep_en, halt_set, halt_clr;
    logic [1:0]          bank_sel;

    gcfg_mem_if #(.AW(9)) mem_bus ();

    function automatic logic [8:0] target_counts(input logic [2:0] field);
        logic [9:0] one;
        one = 10'h001;
        return 9'((one << ({1'b0, field} + `CALIB_EXP_OFFSET)) - 10'h001);
    endfunction : target_counts

    function automatic logic [11:0] stretch(input byte_t period, input logic long_en);
        logic [11:0] wide;
        wide = 12'(period);
        return long_en ? (wide << `STRETCH_SHIFT) : wide;
    endfunction : stretch

    function automatic byte_t merge(input byte_t data, input byte_t mask, input byte_t rst);
        return (data & mask) | (rst & ~mask);
    endfunction : merge

    function automatic logic [8:0] mem_addr(input byte_t idx, input logic [1:0] bank);
        logic in_table;
        in_table = bank[`GEN_BANK_MSB] | (idx > `IDX_LOW_LAST);
        return in_table ? (`TABLE_BASE_ADDR + 9'(idx[`TABLE_IDX_MSB:0]))
                        : {1'b0, bank[`GEN_BANK_LSB], idx[`LOW_IDX_MSB:0]};
    endfunction : mem_addr

    // The interrupt pin comes from outside the clock domain, so it is synchronised first.
    gcfg_sync3 #(
        .IDLE_LEVEL (1'b1)
    ) u_int_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (int_n),
        .level   (int_level)
    );
    assign int_active = ~int_level;

    // Both banks and the table share one memory so a bank switch costs nothing.
    gcfg_ram #(
        .DEPTH (MEM_DEPTH)
    ) u_ram (
        .aclk (aclk),
        .port (mem_bus.mem)
    );

    // Channel handshakes; each address or data beat is held until its request starts.
    assign aw_take   = awvalid & awready_q;
    assign w_take    = wvalid & wready_q;
    assign ar_take   = arvalid & arready_q;
    assign start_wr  = (state_q == ST_IDLE) & aw_have_q & w_have_q;
    assign start_rd  = (state_q == ST_IDLE) & ar_have_q & ~aw_have_q & ~w_have_q;
    assign aw_have_d = (aw_have_q | aw_take) & ~start_wr;
    assign w_have_d  = (w_have_q | w_take) & ~start_wr;
    assign ar_have_d = (ar_have_q | ar_take) & ~start_rd;

    // Writes win over reads when both are complete, so a write is never starved.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (start_wr || start_rd) begin
                    state_d = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                state_d = req_we_q ? ST_BRESP : ST_FETCH;
            end
            ST_FETCH: begin
                state_d = ST_RRESP;
            end
            ST_BRESP: begin
                if (bready) begin
                    state_d = ST_IDLE;
                end
            end
            ST_RRESP: begin
                if (rready) begin
                    state_d = ST_IDLE;
                end
            end
        endcase
    end

    // Channel holding registers and readies.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            ar_have_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            arready_q <= 1'b0;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q  <= w_have_d;
            ar_have_q <= ar_have_d;
            awready_q <= ~aw_have_d;
            wready_q  <= ~w_have_d;
            arready_q <= ~ar_have_d;
        end
    end

    // Payloads are captured without reset; they are only read behind a held flag.
    always_ff @(posedge aclk) begin
        if (aw_take) begin
            aw_addr_q <= awaddr;
        end
        if (w_take) begin
            w_data_q <= wdata[7:0];
            w_be_q   <= wstrb[0];
        end
        if (ar_take) begin
            ar_addr_q <= araddr;
        end
    end

    // Request latch and response channel state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q    <= ST_IDLE;
            req_addr_q <= '0;
            req_data_q <= '0;
            req_we_q   <= 1'b0;
            req_be_q   <= 1'b0;
            resp_q     <= `RESP_OKAY;
            bvalid_q   <= 1'b0;
            rvalid_q   <= 1'b0;
            rdata_q    <= '0;
        end else begin
            state_q  <= state_d;
            bvalid_q <= (state_d == ST_BRESP);
            rvalid_q <= (state_d == ST_RRESP);
            if (start_wr || start_rd) begin
                req_addr_q <= start_wr ? aw_addr_q : ar_addr_q;
                req_data_q <= w_data_q;
                req_be_q   <= w_be_q;
                req_we_q   <= start_wr;
            end
            if (state_q == ST_ACCESS) begin
                resp_q <= hit_any ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (state_q == ST_FETCH) begin
                rdata_q <= hit_mem ? mem_bus.rdata : reg_rd;
            end
        end
    end

    // Address decode; a set address bit above the index makes the access unmapped.
    assign req_idx    = req_addr_q[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
    assign upper_zero = (req_addr_q >> (`ADDR_IDX_MSB + 1)) == '0;
    assign hit_mem    = upper_zero & ((req_idx <= `IDX_LOW_LAST)
                      | ((req_idx >= `IDX_TABLE_FIRST) & (req_idx <= `IDX_TABLE_LAST)));
    assign hit_gen    = upper_zero & (req_idx == `IDX_GENERAL_CONFIG);
    assign hit_xtalk  = upper_zero & (req_idx == `IDX_XTALK_SLEEP);
    assign hit_calib  = upper_zero & (req_idx == `IDX_CALIB_TARGET);
    assign hit_stat   = upper_zero & (req_idx == `IDX_STATUS);
    assign hit_aux    = upper_zero & (req_idx == `IDX_AUX_CONTROL);
    assign hit_any    = hit_mem | hit_gen | hit_xtalk | hit_calib | hit_stat | hit_aux;
    assign wr_fire    = (state_q == ST_ACCESS) & req_we_q & req_be_q & hit_any;
    assign bank_sel   = gen_cfg_q[`GEN_BANK_MSB:`GEN_BANK_LSB];

    assign mem_bus.addr  = mem_addr(req_idx, bank_sel);
    assign mem_bus.we    = wr_fire & hit_mem;
    assign mem_bus.wdata = req_data_q;

    a_bank_low_map : assert property (
        (state_q == ST_ACCESS && upper_zero && req_idx <= `IDX_LOW_LAST && !bank_sel[`GEN_BANK_MSB])
        |-> mem_bus.addr == {bank_sel[`GEN_BANK_LSB], req_idx[`LOW_IDX_MSB:0]})
        else $error("Low window word not routed to the selected bank.");

    a_table_mirror : assert property (
        (state_q == ST_ACCESS && hit_mem && (bank_sel[`GEN_BANK_MSB] || req_idx > `IDX_LOW_LAST))
        |-> mem_bus.addr == `TABLE_BASE_ADDR + 9'(req_idx[`TABLE_IDX_MSB:0]))
        else $error("Time table word not reached through the window.");

    // Status word: halted flag, live interrupt, low power, oscillator stop.
    assign stat_val = byte_t'({osc_stop_q, low_power_q, int_active, osc_halted_q});
    assign reg_rd   = hit_gen   ? gen_cfg_q :
                      hit_xtalk ? xtalk_q :
                      hit_calib ? calib_q :
                      hit_stat  ? stat_val :
                      hit_aux   ? aux_q : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gen_cfg_q <= `GEN_CFG_RESET;
            xtalk_q   <= `XTALK_RESET;
            calib_q   <= `CALIB_RESET;
            aux_q     <= `AUX_RESET;
        end else if (wr_fire) begin
            if (hit_gen) begin
                gen_cfg_q <= merge(req_data_q, `GEN_CFG_MASK, `GEN_CFG_RESET);
            end
            if (hit_xtalk) begin
                xtalk_q <= merge(req_data_q, `XTALK_MASK, `XTALK_RESET);
            end
            if (hit_calib) begin
                calib_q <= merge(req_data_q, `CALIB_MASK, `CALIB_RESET);
            end
            if (hit_aux) begin
                aux_q <= merge(req_data_q, `AUX_MASK, `AUX_RESET);
            end
        end
    end

    a_reserved_fixed : assert property (
        ((xtalk_q & ~`XTALK_MASK) == (`XTALK_RESET & ~`XTALK_MASK))
        && ((gen_cfg_q & ~`GEN_CFG_MASK) == (`GEN_CFG_RESET & ~`GEN_CFG_MASK))
        && ((calib_q & ~`CALIB_MASK) == (`CALIB_RESET & ~`CALIB_MASK)))
        else $error("A reserved bit left its reset value.");

    // Sleep on interrupt: the flag is sticky and a new stop wins over a clear in the same cycle.
    assign sleep_en = xtalk_q[`XTALK_SLEEP_BIT];
    assign halt_set = sleep_en & int_active;
    assign halt_clr = wr_fire & hit_stat & req_data_q[`STAT_HALTED_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_halted_q <= 1'b0;
            osc_stop_q   <= 1'b0;
        end else begin
            osc_halted_q <= halt_set | (osc_halted_q & ~halt_clr);
            osc_stop_q   <= sleep_en & (int_active | osc_halted_q);
        end
    end

    a_sleep_stop : assert property (
        halt_set |=> osc_stop_q && osc_halted_q)
        else $error("Oscillator kept running with sleep on interrupt active.");

    a_halt_sticky : assert property (
        (osc_halted_q && !halt_clr) || halt_set |=> osc_halted_q)
        else $error("Halted flag dropped without a clear, or lost a set.");

    a_restart_hold : assert property (
        (osc_halted_q && sleep_en) |=> osc_stop_q)
        else $error("Oscillator restarted while the halted flag was still set.");

    // Derived controls for the proximity and light engines, all registered.
    // calibration target, low-power, period stretch and high-crosstalk decode.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            calib_target_q <= `CALIB_MIN_COUNTS;
            low_power_q    <= 1'b0;
            prox_eff_q     <= '0;
            wait_eff_q     <= '0;
            high_xtalk_q   <= 1'b0;
        end else begin
            calib_target_q <= target_counts(calib_q[`CALIB_FIELD_MSB:`CALIB_FIELD_LSB]);
            low_power_q    <= gen_cfg_q[`GEN_IDLE_BIT] & all_funcs_idle;
            prox_eff_q     <= stretch(prox_sample_period, gen_cfg_q[`GEN_PROX_LONG_BIT]);
            wait_eff_q     <= stretch(wait_period, gen_cfg_q[`GEN_WAIT_LONG_BIT]);
            high_xtalk_q   <= xtalk_q[`XTALK_SEL_A_BIT] & aux_q[`AUX_SEL_B_BIT];
        end
    end

    a_calib_low : assert property (
        calib_q[`CALIB_FIELD_MSB:`CALIB_FIELD_LSB] == 3'h0 |=> calib_target_q == `CALIB_MIN_COUNTS)
        else $error("Calibration target for field 0 is not 3 counts.");

    a_calib_high : assert property (
        calib_q[`CALIB_FIELD_MSB:`CALIB_FIELD_LSB] == 3'h7 |=> calib_target_q == `CALIB_MAX_COUNTS)
        else $error("Calibration target for field 7 is not 511 counts.");

    a_idle_entry : assert property (
        (gen_cfg_q[`GEN_IDLE_BIT] && all_funcs_idle)
        |=> low_power_q ##1 (low_power_q || !$past(gen_cfg_q[`GEN_IDLE_BIT] && all_funcs_idle)))
        else $error("Low-power mode not entered while all functions idle.");

    a_idle_exit : assert property (
        !all_funcs_idle || !gen_cfg_q[`GEN_IDLE_BIT] |=> !low_power_q)
        else $error("Low-power mode held while a function runs or saving is off.");

    a_prox_stretch : assert property (
        gen_cfg_q[`GEN_PROX_LONG_BIT] |=> prox_eff_q == 12'($past(prox_sample_period)) * 12'h010)
        else $error("Proximity period not stretched by sixteen.");

    a_wait_plain : assert property (
        !gen_cfg_q[`GEN_WAIT_LONG_BIT] |=> wait_eff_q == 12'($past(wait_period)))
        else $error("Wait period changed while stretch is off.");

    a_wait_stretch : assert property (
        gen_cfg_q[`GEN_WAIT_LONG_BIT] |=> wait_eff_q == 12'($past(wait_period)) * 12'h010)
        else $error("Wait period not stretched by sixteen.");

    a_xtalk_both : assert property (
        !(xtalk_q[`XTALK_SEL_A_BIT] && aux_q[`AUX_SEL_B_BIT]) |=> !high_xtalk_q)
        else $error("High-crosstalk mode on with only one select bit.");

    a_xtalk_on : assert property (
        (xtalk_q[`XTALK_SEL_A_BIT] && aux_q[`AUX_SEL_B_BIT]) |=> high_xtalk_q)
        else $error("High-crosstalk mode off with both select bits set.");

    a_write_answer : assert property (
        start_wr |=> state_q == ST_ACCESS ##1 bvalid_q)
        else $error("Write response not raised two cycles after start.");

    // Bus outputs come straight from their flip-flops; upper data bits read as zero.
    assign awready = awready_q;
    assign wready  = wready_q;
    assign arready = arready_q;
    assign bvalid  = bvalid_q;
    assign bresp   = resp_q;
    assign rvalid  = rvalid_q;
    assign rresp   = resp_q;
    assign rdata   = 32'(rdata_q);

    // Engine controls, each from its own register.
    assign calib_target    = calib_target_q;
    assign low_power_mode  = low_power_q;
    assign prox_period_eff = prox_eff_q;
    assign wait_period_eff = wait_eff_q;
    assign high_xtalk_mode = high_xtalk_q;
    assign osc_stop        = osc_stop_q;
endmodule : sensor_general_config_regs
